// ===== design/stop_mode_controller.sv
// Stop-mode controller: chooses deep or retention stop, gates clocks,
// freezes pins and sequences every wake-up path.
// Assumes rstn is a power-on reset; the rest of the chip is reset by system_reset.
//
// Summary of operation
// - Enabled STOP enters a stop, clocks halt.
// - Disabled STOP forces illegal opcode reset.
// - Deep stop needs select, enable, LOW_VOLTAGE_DETECT unarmed.
// - Armed LOW_VOLTAGE_DETECT makes STOP choose retention.
// - Deep entry freezes pins until acknowledge.
// - Deep exit by reset, IRQ or timer.
// - IRQ is active low during deep stop.
// - IRQ pull-up follows software bit only.
// - Deep wake restarts chip, pins stay frozen.
// - Wake flag and freeze hold until acknowledge.
// - Unreloaded port bits show reset values after release.
// - Disabled peripheral pins follow port registers.
// - Retention stop keeps all state.
// - Retention exit by reset or five interrupts.
// - Reset exit resets; interrupt exit resumes.
// - Debug enabled keeps debug clock and regulator.
// - Debug enabled turns deep into retention.
// - Stop blocks status commands; BACKGROUND wakes.
// - Armed LOW_VOLTAGE_DETECT keeps regulator, forbids deep.
// - Peripheral clocks stop in every stop.
// - ADC runs in retention only if allowed and LOW_VOLTAGE_DETECT armed.
// - Clock source optional in retention stop only, timer in every stop.
//
// Implementation choices: strobed register access and the address map.
`timescale 1ns/1ps
module stop_mode_controller (
    input  wire logic       clock,
    input  wire logic       rstn,
    input  wire logic [3:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    input  wire logic       reg_write,
    input  wire logic       reg_read,
    output logic      [7:0] reg_rdata,
    input  wire logic       stop_exec,
    input  wire logic       debug_mode_entry_enable,
    input  wire logic       background_cmd,
    input  wire logic       mem_status_cmd,
    input  wire logic       reset_pin_n,
    input  wire logic       irq_pin_n,
    input  wire logic       periodic_wakeup_interrupt,
    input  wire logic       low_voltage_detect_irq,
    input  wire logic       adc_irq,
    input  wire logic       irq_pin_irq,
    input  wire logic       keypad_interrupt,
    input  wire logic [5:0] port_data,
    input  wire logic [5:0] port_dir,
    input  wire logic [5:0] periph_data,
    input  wire logic [5:0] periph_dir,
    input  wire logic [5:0] periph_sel,
    output logic      [5:0] pin_out,
    output logic      [5:0] pin_oe,
    output logic            cpu_clock_run,
    output logic            periph_clock_run,
    output logic            debug_clock_run,
    output logic            regulator_full,
    output logic      [1:0] adc_mode,
    output logic            internal_clock_source_run,
    output logic            rti_clock_run,
    output logic            irq_force_active_low,
    output logic            irq_pullup_enable,
    output logic            system_reset,
    output logic            illegal_opcode_reset,
    output logic            interrupt_resume,
    output logic            debug_wake,
    output logic            mem_status_error,
    output logic            stop_active
);

    // Pin synchronisers; only the second stage is read by logic.
    logic [1:0] rst_pin_sync_q; // Reset pin chain.
    logic [1:0] irq_pin_sync_q; // IRQ pin chain.
    logic       rst_low;        // Reset pin asserted, synchronised.
    logic       irq_low;        // IRQ pin asserted, synchronised.

    // Two flops per pin since both pins are asynchronous to the bus clock.
    always_ff @(posedge clock) begin
        if (!rstn) begin
            rst_pin_sync_q <= 2'h3;
            irq_pin_sync_q <= 2'h3;
        end else begin
            rst_pin_sync_q <= {rst_pin_sync_q[0], reset_pin_n};
            irq_pin_sync_q <= {irq_pin_sync_q[0], irq_pin_n};
        end
    end

    assign rst_low = !rst_pin_sync_q[1];
    assign irq_low = !irq_pin_sync_q[1];

    // Software state.
    logic       pds_q;    // Partial power-down select.
    logic       stop_enable_q;  // Stop enable.
    logic [5:0] cfg_q;    // Stop configuration bits.
    logic       flag_q;   // Power-down wake flag.
    logic       hold_q;   // Pin freeze closed.
    logic       dbg_q;    // Debug enable captured at STOP.

    stop_mode_pkg::stop_state_t state_q; // Controller state.
    stop_mode_pkg::stop_state_t state_d; // Next controller state.

    // Decoded conditions.
    logic ack_wr;    // A one written to the acknowledge bit.
    logic lvd_armed; // Both low-voltage enables set.
    logic go_deep;   // STOP would select deep power-down.
    logic ret_int;   // Any retention wake interrupt.
    logic in_stop;   // Either stop state.

    // Register address decode, shared by write and read paths.
    function automatic logic hit(input logic [3:0] addr, input logic [3:0] ofs);
        return addr == ofs;
    endfunction

    assign ack_wr = reg_write && hit(reg_addr, stop_mode_pkg::POWER_MODE_CONTROL_OFS)
                    && reg_wdata[stop_mode_pkg::ACK_BIT];
    assign lvd_armed = cfg_q[stop_mode_pkg::LOW_VOLTAGE_DETECT_ENABLE_BIT] && cfg_q[stop_mode_pkg::LOW_VOLTAGE_DETECT_STOP_ENABLE_BIT];
    // Deep only with select and enable set, LOW_VOLTAGE_DETECT unarmed and debug disabled.
    assign go_deep = pds_q && stop_enable_q && !lvd_armed && !debug_mode_entry_enable;
    assign ret_int = periodic_wakeup_interrupt || low_voltage_detect_irq || adc_irq
                     || irq_pin_irq || keypad_interrupt;
    assign in_stop = (state_q == stop_mode_pkg::ST_RET) || (state_q == stop_mode_pkg::ST_DEEP);

    // Next-state logic. The reset pin has priority over every other wake source.
    always_comb begin
        state_d = state_q;
        case (state_q)
            stop_mode_pkg::ST_RUN: begin
                if (rst_low) begin
                    state_d = stop_mode_pkg::ST_WAKE;
                end else if (stop_exec && stop_enable_q) begin
                    // Armed LOW_VOLTAGE_DETECT or debug fall back to retention.
                    state_d = go_deep ? stop_mode_pkg::ST_DEEP : stop_mode_pkg::ST_RET;
                end
            end
            stop_mode_pkg::ST_RET: begin
                if (rst_low) begin
                    state_d = stop_mode_pkg::ST_WAKE;
                end else if (ret_int || (background_cmd && dbg_q)) begin
                    state_d = stop_mode_pkg::ST_RUN;
                end
            end
            stop_mode_pkg::ST_DEEP: begin
                // IRQ is taken as active low whatever its prior setup.
                if (rst_low || irq_low || periodic_wakeup_interrupt) begin
                    state_d = stop_mode_pkg::ST_WAKE;
                end
            end
            stop_mode_pkg::ST_WAKE: begin
                state_d = stop_mode_pkg::ST_RUN;
            end
            default: begin
                state_d = stop_mode_pkg::ST_RUN;
            end
        endcase
    end

    // State register.
    always_ff @(posedge clock) begin
        if (!rstn) begin
            state_q <= stop_mode_pkg::ST_RUN;
        end else begin
            state_q <= state_d;
        end
    end

    // Debug enable is sampled when STOP executes, not followed during stop.
    always_ff @(posedge clock) begin
        if (!rstn) begin
            dbg_q <= 1'b0;
        end else if (state_q == stop_mode_pkg::ST_RUN && stop_exec) begin
            dbg_q <= debug_mode_entry_enable;
        end
    end

    // Control bits. A deep wake resets them like every peripheral, while
    // flag and freeze survive because only power-on reset or acknowledge clears those.
    always_ff @(posedge clock) begin
        if (!rstn || state_q == stop_mode_pkg::ST_WAKE) begin
            pds_q   <= stop_mode_pkg::PDS_RST;
            stop_enable_q <= stop_mode_pkg::STOP_ENABLE_RST;
            cfg_q   <= stop_mode_pkg::CFG_RST;
        end else if (reg_write) begin
            if (hit(reg_addr, stop_mode_pkg::POWER_MODE_CONTROL_OFS)) begin
                pds_q   <= reg_wdata[stop_mode_pkg::PDS_BIT];
                stop_enable_q <= reg_wdata[stop_mode_pkg::STOP_ENABLE_BIT];
            end
            if (hit(reg_addr, stop_mode_pkg::STOP_CONFIG_OFS)) begin
                cfg_q <= reg_wdata[stop_mode_pkg::CFG_W-1:0];
            end
        end
    end

    // Wake flag: set on deep wake, cleared by acknowledge; the set wins.
    always_ff @(posedge clock) begin
        if (!rstn) begin
            flag_q <= 1'b0;
        end else if (state_q == stop_mode_pkg::ST_DEEP && state_d == stop_mode_pkg::ST_WAKE) begin
            flag_q <= 1'b1;
        end else if (ack_wr) begin
            flag_q <= 1'b0;
        end
    end

    // Pin freeze: closes on deep entry, opens only on acknowledge.
    always_ff @(posedge clock) begin
        if (!rstn) begin
            hold_q <= 1'b0;
        end else if (state_d == stop_mode_pkg::ST_DEEP) begin
            hold_q <= 1'b1;
        end else if (ack_wr) begin
            hold_q <= 1'b0;
        end
    end

    // Pin hold latch. Port registers reset on wake, so unrestored bits
    // reach the pins as reset values once the freeze opens.
    pin_hold_if pins ();

    assign pins.port_data   = port_data;
    assign pins.port_dir    = port_dir;
    assign pins.periph_data = periph_data;
    assign pins.periph_dir  = periph_dir;
    assign pins.periph_sel  = periph_sel;
    assign pins.hold        = hold_q;

    pin_hold u_pin_hold (
        .clock (clock),
        .rstn  (rstn),
        .pins  (pins.latch)
    );

    assign pin_out = pins.pin_out;
    assign pin_oe  = pins.pin_oe;

    // Event pulses, registered so they are clean single-cycle outputs.
    logic illegal_q; // Illegal opcode reset request.
    logic resume_q;  // Interrupt exit from retention.
    logic dwake_q;   // Background command woke the device.
    logic merr_q;    // Status command refused during stop.

    // Pulse generation for the CPU and debug controller.
    always_ff @(posedge clock) begin
        if (!rstn) begin
            illegal_q <= 1'b0;
            resume_q  <= 1'b0;
            dwake_q   <= 1'b0;
            merr_q    <= 1'b0;
        end else begin
            illegal_q <= state_q == stop_mode_pkg::ST_RUN && stop_exec && !stop_enable_q
                         && !rst_low;
            resume_q  <= state_q == stop_mode_pkg::ST_RET && !rst_low && ret_int;
            dwake_q   <= state_q == stop_mode_pkg::ST_RET && !rst_low && !ret_int
                         && background_cmd && dbg_q;
            merr_q    <= in_stop && mem_status_cmd;
        end
    end

    assign illegal_opcode_reset = illegal_q;
    assign interrupt_resume     = resume_q;
    assign debug_wake           = dwake_q;
    assign mem_status_error     = merr_q;

    // Clock and power controls decoded from the one-hot state flops.
    // Retention keeps state simply by withholding clocks, not resetting.
    always_comb begin
        stop_active      = in_stop;
        cpu_clock_run    = !in_stop;
        periph_clock_run = !in_stop;
        debug_clock_run  = !in_stop || dbg_q;
        regulator_full   = !in_stop || dbg_q || lvd_armed;
        system_reset     = state_q == stop_mode_pkg::ST_WAKE;
        irq_force_active_low = state_q == stop_mode_pkg::ST_DEEP;
        irq_pullup_enable    = cfg_q[stop_mode_pkg::PUE_BIT];
        internal_clock_source_run = !in_stop || (state_q == stop_mode_pkg::ST_RET
                                    && cfg_q[stop_mode_pkg::ICS_BIT]);
        rti_clock_run = !in_stop || cfg_q[stop_mode_pkg::RTI_BIT];
        if (state_q == stop_mode_pkg::ST_DEEP) begin
            adc_mode = stop_mode_pkg::ADC_OFF;
        end else if (state_q == stop_mode_pkg::ST_RET) begin
            adc_mode = (cfg_q[stop_mode_pkg::ADCK_BIT] && lvd_armed) ?
                       stop_mode_pkg::ADC_RUN : stop_mode_pkg::ADC_STANDBY;
        end else begin
            adc_mode = stop_mode_pkg::ADC_RUN;
        end
    end

    // Read path: data stand the cycle after the strobe, zero otherwise.
    // The acknowledge bit is never stored, so it always reads zero.
    always_ff @(posedge clock) begin
        if (!rstn) begin
            reg_rdata <= 8'h00;
        end else if (reg_read && hit(reg_addr, stop_mode_pkg::POWER_MODE_CONTROL_OFS)) begin
            reg_rdata <= {4'h0, stop_enable_q, flag_q, 1'b0, pds_q};
        end else if (reg_read && hit(reg_addr, stop_mode_pkg::STOP_CONFIG_OFS)) begin
            reg_rdata <= {2'h0, cfg_q};
        end else if (reg_read && hit(reg_addr, stop_mode_pkg::STOP_STATUS_OFS)) begin
            reg_rdata <= {3'h0, hold_q, state_q};
        end else begin
            reg_rdata <= 8'h00;
        end
    end

    // Checks on the sequencing above.
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rstn);

    sequence deep_wake_s;
        state_q == stop_mode_pkg::ST_DEEP && irq_low && !rst_low;
    endsequence

    sequence wake_done_s;
        system_reset && flag_q ##1 state_q == stop_mode_pkg::ST_RUN && flag_q && hold_q;
    endsequence

    illegal_stop_a: assert property (
        state_q == stop_mode_pkg::ST_RUN && stop_exec && !stop_enable_q && !rst_low
        |=> illegal_opcode_reset && state_q == stop_mode_pkg::ST_RUN)
        else $error("disabled STOP did not force illegal opcode reset");

    deep_entry_a: assert property (
        state_q == stop_mode_pkg::ST_RUN && stop_exec && stop_enable_q && pds_q && !lvd_armed
        && !debug_mode_entry_enable && !rst_low
        |=> state_q == stop_mode_pkg::ST_DEEP && hold_q && irq_force_active_low)
        else $error("deep stop not entered");

    lvd_retention_a: assert property (
        state_q == stop_mode_pkg::ST_RUN && stop_exec && stop_enable_q && lvd_armed && !rst_low
        |=> state_q == stop_mode_pkg::ST_RET && regulator_full)
        else $error("armed LOW_VOLTAGE_DETECT did not force retention stop");

    debug_retention_a: assert property (
        state_q == stop_mode_pkg::ST_RUN && stop_exec && stop_enable_q && debug_mode_entry_enable
        && !rst_low |=> state_q == stop_mode_pkg::ST_RET && debug_clock_run && regulator_full)
        else $error("debug enable did not force retention stop");

    stop_clocks_a: assert property (
        stop_active |-> !cpu_clock_run && !periph_clock_run)
        else $error("clocks running during stop");

    deep_wake_a: assert property (
        deep_wake_s |=> wake_done_s)
        else $error("deep wake sequence wrong");

    ack_release_a: assert property (
        hold_q && ack_wr && state_q == stop_mode_pkg::ST_RUN && !stop_exec
        |=> !hold_q && !flag_q)
        else $error("acknowledge did not release pins");

    ack_reads_zero_a: assert property (
        reg_read && hit(reg_addr, stop_mode_pkg::POWER_MODE_CONTROL_OFS)
        |=> !reg_rdata[stop_mode_pkg::ACK_BIT] && reg_rdata[stop_mode_pkg::FLAG_BIT] == $past(flag_q))
        else $error("acknowledge bit read back nonzero");

    ret_resume_a: assert property (
        state_q == stop_mode_pkg::ST_RET && ret_int && !rst_low
        |=> interrupt_resume && state_q == stop_mode_pkg::ST_RUN && !system_reset)
        else $error("interrupt exit from retention wrong");

endmodule

// ===== design/stop_mode_pkg.sv
// Package for the stop-mode controller: register map, field positions,
// reset values and the controller state encoding.
// Assumes an 8-bit register port with a 4-bit word address.
package stop_mode_pkg;

    // Register widths of the plain register port.
    localparam int ADDR_W = 4;
    localparam int DATA_W = 8;
    localparam int PIN_N  = 6;

    // Register offsets.
    localparam logic [3:0] POWER_MODE_CONTROL_OFS = 4'h0;
    localparam logic [3:0] STOP_CONFIG_OFS        = 4'h1;
    localparam logic [3:0] STOP_STATUS_OFS        = 4'h2;

    // Field positions in power_mode_control_reg.
    localparam int PDS_BIT   = 0;  // partial_powerdown_select
    localparam int ACK_BIT   = 1;  // powerdown_ack, write only
    localparam int FLAG_BIT  = 2;  // powerdown_wake_flag, read only
    localparam int STOP_ENABLE_BIT = 3;  // stop_enable

    // Field positions in the stop configuration register.
    localparam int LOW_VOLTAGE_DETECT_ENABLE_BIT  = 0;  // low_voltage_detect_enable
    localparam int LOW_VOLTAGE_DETECT_STOP_ENABLE_BIT = 1;  // low_voltage_detect_stop_enable
    localparam int PUE_BIT   = 2;  // irq_pullup_enable
    localparam int ICS_BIT   = 3;  // internal clock source runs in retention stop
    localparam int RTI_BIT   = 4;  // periodic wakeup timer runs in stop
    localparam int ADCK_BIT  = 5;  // ADC asynchronous clock enabled
    localparam int CFG_W     = 6;

    // Reset values.
    localparam logic       PDS_RST   = 1'b0;
    localparam logic       STOP_ENABLE_RST = 1'b0;
    localparam logic [5:0] CFG_RST   = 6'h00;

    // ADC operating mode codes.
    localparam logic [1:0] ADC_OFF     = 2'h0;
    localparam logic [1:0] ADC_STANDBY = 2'h1;
    localparam logic [1:0] ADC_RUN     = 2'h2;

    // Controller states, one-hot.
    typedef enum logic [3:0] {
        ST_RUN  = 4'h1,
        ST_RET  = 4'h2,
        ST_DEEP = 4'h4,
        ST_WAKE = 4'h8
    } stop_state_t;

endpackage

// ===== design/pin_hold_if.sv
// Interface between the stop controller and the pin hold latch.
// Assumes both ends share the controller clock.
`timescale 1ns/1ps
interface pin_hold_if;
    logic [5:0] port_data;   // Port data register outputs.
    logic [5:0] port_dir;    // Port direction register outputs.
    logic [5:0] periph_data; // Peripheral output values.
    logic [5:0] periph_dir;  // Peripheral output enables.
    logic [5:0] periph_sel;  // Peripheral owns the pin when high.
    logic       hold;        // Pins frozen while high.
    logic [5:0] pin_out;     // Resolved pin values.
    logic [5:0] pin_oe;      // Resolved pin enables.

    modport ctrl (output port_data, port_dir, periph_data, periph_dir, periph_sel, hold,
                  input pin_out, pin_oe);
    modport latch (input port_data, port_dir, periph_data, periph_dir, periph_sel, hold,
                   output pin_out, pin_oe);
endinterface

// ===== design/pin_hold.sv
// Pin hold latch: resolves port against peripheral drive and freezes
// the result while the hold is closed.
// Assumes the same clock and power-on reset as the stop controller.
`timescale 1ns/1ps
module pin_hold (
    input wire logic clock,
    input wire logic rstn,
    pin_hold_if.latch pins
);

    // Live pin drive: an unselected peripheral leaves the pin to its port.
    logic [5:0] live_out; // Value the pin would take now.
    logic [5:0] live_oe;  // Enable the pin would take now.

    // Selection of the pin owner, port registers unless the peripheral is on.
    always_comb begin
        live_out = (pins.periph_sel & pins.periph_data) | (~pins.periph_sel & pins.port_data);
        live_oe  = (pins.periph_sel & pins.periph_dir) | (~pins.periph_sel & pins.port_dir);
    end

    logic [5:0] out_q; // Held pin values.
    logic [5:0] oe_q;  // Held pin enables.

    // The flops track the live drive until the hold closes, then keep it.
    always_ff @(posedge clock) begin
        if (!rstn) begin
            out_q <= 6'h00;
            oe_q  <= 6'h00;
        end else if (!pins.hold) begin
            out_q <= live_out;
            oe_q  <= live_oe;
        end
    end

    assign pins.pin_out = out_q;
    assign pins.pin_oe  = oe_q;

endmodule

// ===== bench/wake_pin_model.sv
// Wake pin model: drives the reset and IRQ pins the way an outside switch would.
// Assumes the same clock as the bench; requests are one-cycle pulses.
`timescale 1ns/1ps
module wake_pin_model (
    input  wire logic clock,
    input  wire logic irq_req,
    input  wire logic rst_req,
    output logic      irq_pin_n,
    output logic      reset_pin_n
);
    logic [2:0] irq_cnt_q = 3'h0; // Cycles left with the IRQ pin pulled low.
    logic [2:0] rst_cnt_q = 3'h0; // Cycles left with the reset pin pulled low.

    // Four low cycles outlast the two-flop synchroniser, so no press is missed.
    always_ff @(posedge clock) begin
        irq_cnt_q <= irq_req ? 3'h4 : ((irq_cnt_q != 3'h0) ? irq_cnt_q - 3'h1 : 3'h0);
    end

    // The reset pin is counted the same way.
    always_ff @(posedge clock) begin
        rst_cnt_q <= rst_req ? 3'h4 : ((rst_cnt_q != 3'h0) ? rst_cnt_q - 3'h1 : 3'h0);
    end

    // Released pins sit at their pull-up level, so high is the idle value.
    assign irq_pin_n   = (irq_cnt_q == 3'h0);
    assign reset_pin_n = (rst_cnt_q == 3'h0);
endmodule

// ===== bench/tb.sv
// Testbench for the stop-mode controller: registers, stop entry and the retention, deep IRQ and BACKGROUND wake paths.
// Assumes the design files and the wake pin model are compiled first.
`timescale 1ns/1ps
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin err_count++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, e); end end
module tb;
    logic       clock = 1'b0;  // Bus clock, 25 ns period.
    logic       rstn = 1'b0;   // Power-on reset, low active.
    logic [3:0] reg_addr = 4'h0;
    logic [7:0] reg_wdata = 8'h00;
    logic       reg_write = 1'b0;
    logic       reg_read = 1'b0;
    logic       stop_exec = 1'b0;
    logic       dbg = 1'b0;    // Debug entry enable.
    logic       bg = 1'b0;     // BACKGROUND command.
    logic       mem_cmd = 1'b0; // Memory-with-status command.
    logic       irq_req = 1'b0;
    logic       rst_req = 1'b0;
    logic [4:0] ints = 5'h00;  // Timer, voltage, ADC, IRQ and keypad requests.
    logic [5:0] port_data = 6'h00, port_dir = 6'h00, periph_data = 6'h00;
    logic [5:0] periph_dir = 6'h00, periph_sel = 6'h00;
    wire logic [7:0] reg_rdata;
    wire logic [5:0] pin_out, pin_oe;
    wire logic [1:0] adc_mode;
    wire logic irq_pin_n, reset_pin_n, cpu_clock_run, periph_clock_run, debug_clock_run;
    wire logic regulator_full, internal_clock_source_run, rti_clock_run, irq_force_active_low;
    wire logic irq_pullup_enable, system_reset, illegal_opcode_reset, interrupt_resume;
    wire logic debug_wake, mem_status_error, stop_active;
    int err_count = 0;
    int checks_done = 0;

    // The bus clock toggles every half period.
    always #12.5 clock = ~clock;

    wake_pin_model pins (.clock(clock), .irq_req(irq_req), .rst_req(rst_req),
        .irq_pin_n(irq_pin_n), .reset_pin_n(reset_pin_n));

    stop_mode_controller dut (.clock(clock), .rstn(rstn), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
        .reg_rdata(reg_rdata), .stop_exec(stop_exec), .debug_mode_entry_enable(dbg),
        .background_cmd(bg), .mem_status_cmd(mem_cmd), .reset_pin_n(reset_pin_n),
        .irq_pin_n(irq_pin_n), .periodic_wakeup_interrupt(ints[0]),
        .low_voltage_detect_irq(ints[1]), .adc_irq(ints[2]), .irq_pin_irq(ints[3]),
        .keypad_interrupt(ints[4]), .port_data(port_data), .port_dir(port_dir),
        .periph_data(periph_data), .periph_dir(periph_dir), .periph_sel(periph_sel),
        .pin_out(pin_out), .pin_oe(pin_oe), .cpu_clock_run(cpu_clock_run),
        .periph_clock_run(periph_clock_run), .debug_clock_run(debug_clock_run),
        .regulator_full(regulator_full), .adc_mode(adc_mode),
        .internal_clock_source_run(internal_clock_source_run),
        .rti_clock_run(rti_clock_run), .irq_force_active_low(irq_force_active_low),
        .irq_pullup_enable(irq_pullup_enable), .system_reset(system_reset),
        .illegal_opcode_reset(illegal_opcode_reset), .interrupt_resume(interrupt_resume),
        .debug_wake(debug_wake), .mem_status_error(mem_status_error),
        .stop_active(stop_active));

    // Prints the counts and the verdict, then ends the run.
    task automatic summarize;
        $display("checks_done=%0d err_count=%0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // One-cycle write strobe.
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clock);
        reg_write <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge clock);
        reg_write <= 1'b0;
    endtask

    // One-cycle read strobe; the word is judged in the cycle after it, its only valid cycle.
    task automatic rd(input logic [3:0] a, input logic [7:0] e);
        @(posedge clock);
        reg_read <= 1'b1;
        reg_addr <= a;
        @(posedge clock);
        reg_read <= 1'b0;
        #1;
        `CHK(reg_rdata, e)
    endtask

    // One STOP instruction; returns once the taking edge has settled.
    task automatic stop_cmd;
        @(posedge clock);
        stop_exec <= 1'b1;
        @(posedge clock);
        stop_exec <= 1'b0;
        #1;
    endtask

    // Waits a bounded time for the restart pulse; running out ends the run.
    task automatic wait_rst;
        int n;
        n = 0;
        while (system_reset !== 1'b1 && n < 20) begin
            @(posedge clock);
            #1 n++;
        end
        if (n >= 20) begin
            err_count++;
            summarize();
        end
    endtask

    // Reset values, an unmapped address and a disabled STOP.
    task automatic t_reset;
        rd(4'h0, 8'h00);
        rd(4'h1, 8'h00);
        rd(4'h2, 8'h01);
        rd(4'hf, 8'h00);
        stop_cmd();
        `CHK(illegal_opcode_reset, 1'b1)
        `CHK(stop_active, 1'b0)
        $display("test reset done");
    endtask

    // Armed voltage detect turns a deep request into retention; all five sources wake it.
    task automatic t_retention;
        wr(4'h1, 8'h3b);
        for (int k = 0; k < 5; k++) begin
            wr(4'h0, 8'h09);
            stop_cmd();
            `CHK(cpu_clock_run, 1'b0)
            `CHK(periph_clock_run, 1'b0)
            `CHK(regulator_full, 1'b1)
            `CHK(adc_mode, stop_mode_pkg::ADC_RUN)
            `CHK({internal_clock_source_run, rti_clock_run}, 2'h3)
            rd(4'h2, 8'h02);
            @(posedge clock);
            ints <= 5'h01 << k;
            @(posedge clock);
            ints <= 5'h00;
            #1;
            `CHK({interrupt_resume, system_reset, stop_active}, 3'h4)
        end
        stop_cmd();
        @(posedge clock);
        rst_req <= 1'b1;
        @(posedge clock);
        rst_req <= 1'b0;
        wait_rst();
        rd(4'h1, 8'h00);
        $display("test retention done");
    endtask

    // Deep stop freezes pins, IRQ pin wakes it, acknowledge releases the pins.
    task automatic t_deep;
        port_data <= 6'h2a;
        port_dir <= 6'h3f;
        periph_sel <= 6'h01;
        periph_data <= 6'h01;
        periph_dir <= 6'h01;
        wr(4'h0, 8'h09);
        stop_cmd();
        `CHK({irq_force_active_low, irq_pullup_enable}, 2'h2)
        `CHK(adc_mode, stop_mode_pkg::ADC_OFF)
        rd(4'h2, 8'h14);
        port_data <= 6'h15;
        periph_sel <= 6'h00;
        rd(4'h2, 8'h14);
        `CHK(pin_out, 6'h2b)
        irq_req <= 1'b1;
        @(posedge clock);
        irq_req <= 1'b0;
        wait_rst();
        rd(4'h0, 8'h04);
        rd(4'h2, 8'h11);
        `CHK({pin_out, pin_oe}, 12'haff)
        port_dir <= 6'h00;
        wr(4'h0, 8'h00);
        rd(4'h0, 8'h04);
        wr(4'h0, 8'h02);
        rd(4'h0, 8'h00);
        `CHK({pin_out, pin_oe}, 12'h540)
        $display("test deep done");
    endtask

    // Debug entry enabled: retention instead of deep, status commands refused.
    task automatic t_debug;
        dbg <= 1'b1;
        wr(4'h1, 8'h04);
        wr(4'h0, 8'h09);
        stop_cmd();
        `CHK({debug_clock_run, regulator_full}, 2'h3)
        `CHK({adc_mode, irq_pullup_enable}, {stop_mode_pkg::ADC_STANDBY, 1'b1})
        rd(4'h2, 8'h02);
        mem_cmd <= 1'b1;
        @(posedge clock);
        mem_cmd <= 1'b0;
        #1;
        `CHK({mem_status_error, stop_active}, 2'h3)
        bg <= 1'b1;
        @(posedge clock);
        bg <= 1'b0;
        #1;
        `CHK({debug_wake, stop_active}, 2'h2)
        $display("test debug done");
    endtask

    // Reset for 16 cycles, then each scenario in turn.
    initial begin
        repeat (16) @(posedge clock);
        rstn <= 1'b1;
        t_reset();
        t_retention();
        t_deep();
        t_debug();
        summarize();
    end
endmodule
